// File: common/vr_fault_supervisor_params.svh
// offsets, field positions, reset values and timing counts of the supervisor
`ifndef VR_FAULT_SUPERVISOR_PARAMS_SVH
`define VR_FAULT_SUPERVISOR_PARAMS_SVH

// ***************************************************************
// clock and timing
// ***************************************************************
`define REF_CLK_MHZ          250
`define READY_DELAY_NS       85000
`define READY_DELAY_CYC      ((`READY_DELAY_NS * `REF_CLK_MHZ) / 1000)
`define GUARD_RESP_NS        20
`define GUARD_RESP_CYC       ((`GUARD_RESP_NS * `REF_CLK_MHZ) / 1000)
`define HICCUP_SW_CYCLES     4096
`define CHAN_OC_RUN          8
`define CHANNELS             6

// ***************************************************************
// register map
// ***************************************************************
`define ADDR_W               8
`define REG_CTRL             8'h00
`define REG_STATUS           8'h04
`define REG_RETRIES          8'h08
`define CTRL_RESET           32'h0000_0000
`define CTRL_SW_OFF_BIT      0

// status field positions
`define ST_PGOOD_BIT         0
`define ST_OV_LATCH_BIT      1
`define ST_OV_LOW_BIT        2
`define ST_HICCUP_BIT        3
`define ST_UV_BIT            4
`define ST_FAN_BIT           5
`define ST_HOT_BIT           6
`define ST_VID_OK_BIT        7
`define ST_VID_OFF_BIT       8
`define ST_STATE_LSB         12

`endif

// File: common/vr_fault_supervisor_pkg.sv
// types shared by the fault supervisor
package vr_fault_supervisor_pkg;

  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,
    ST_RUN    = 2'b01,
    ST_HICCUP = 2'b10,
    ST_OV     = 2'b11
  } sup_state_t;

endpackage

// File: hdl/vr_fault_supervisor.sv
// fault supervisor: power good, overvoltage, overcurrent hiccup, thermal
`timescale 1ns/1ps
`include "vr_fault_supervisor_params.svh"

// Overview of operation
// - power good low in shutdown; high after soft-start done plus ready delay
// - power good low on under/overvoltage, disable, reset or off-code
// - undervoltage below half of VID holds power good low
// - undervoltage clears only when output recovers to sixty percent of VID
// - overvoltage guard active from reset whether enabled or not
// - fixed overvoltage level used until a valid VID is seen
// - after valid VID, trip level is VID plus 175mV
// - overvoltage drives all PWM low until diff sense falls below 0.4V
// - after diff sense below limit, PWM outputs go high impedance
// - each recurring overvoltage drives PWM low again, without limit
// - overvoltage stops normal switching until an enable, software off or supply cycles
// - VID code changes never clear a latched overvoltage
// - average current above reference starts overcurrent shutdown at once
// - one channel over reference eight straight switching cycles trips
// - overcurrent shutdown puts every PWM output in high impedance quickly
// - stay off 4096 switching cycles, then soft-start again if enabled
// - hiccup shutdown, wait, retry repeats until disabled or fault gone
// - fan request released below 33%, pulled low above 39% of supply
// - overtemp alert released below 28%, pulled low above 33% of supply
// - fan and overtemp outputs are open drain: pull low or release
// - all PWM outputs high impedance while in shutdown
// - off-code after boot plateau shuts down until enable or supply cycles
module vr_fault_supervisor #(
  parameter int unsigned READY_DELAY_CYCLES = `READY_DELAY_CYC,
  parameter int unsigned HICCUP_CYCLES      = `HICCUP_SW_CYCLES
) (
  input  wire logic                   ref_clk_i,
  input  wire logic                   rst_n_i,
  // enable comparators
  input  wire logic                   power_enable_in_i,
  input  wire logic                   rail_enable_in_i,
  // voltage comparator flags
  input  wire logic                   uv_below_half_i,
  input  wire logic                   uv_above_sixty_i,
  input  wire logic                   ov_fixed_trip_i,
  input  wire logic                   ov_vid_trip_i,
  input  wire logic                   diff_sense_low_i,
  // current comparator flags
  input  wire logic                   avg_oc_i,
  input  wire logic [`CHANNELS-1:0]   chan_oc_i,
  // thermal comparator flags
  input  wire logic                   tm_below_28_i,
  input  wire logic                   tm_below_33_i,
  input  wire logic                   tm_above_33_i,
  input  wire logic                   tm_above_39_i,
  // soft-start sequencer and modulator, same clock
  input  wire logic                   sw_cycle_tick_i,
  input  wire logic                   softstart_done_i,
  input  wire logic                   vid_valid_i,
  input  wire logic                   vid_off_i,
  input  wire logic [`CHANNELS-1:0]   pwm_i,
  output logic                        softstart_run_o,
  output logic                        softstart_restart_o,
  // PWM pins to the MOSFET drivers
  output logic      [`CHANNELS-1:0]   pwm_o,
  output logic      [`CHANNELS-1:0]   pwm_oe_o,
  // open-drain status pins
  output logic                        power_good_out_o,
  output logic                        power_good_out_oe_o,
  output logic                        fan_request_out_o,
  output logic                        fan_request_out_oe_o,
  output logic                        overtemp_alert_out_o,
  output logic                        overtemp_alert_out_oe_o,
  // register port
  input  wire logic [`ADDR_W-1:0]     reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [31:0]            reg_rdata_o
);

  // ***************************************************************
  // input synchronisers
  // ***************************************************************
  localparam int unsigned NSYNC = 11 + `CHANNELS;

  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  wire  [NSYNC-1:0] async_in;

  assign async_in = {chan_oc_i, avg_oc_i, tm_above_39_i, tm_above_33_i,
                     tm_below_33_i, tm_below_28_i, diff_sense_low_i,
                     ov_vid_trip_i, ov_fixed_trip_i, uv_above_sixty_i,
                     uv_below_half_i, power_enable_in_i & rail_enable_in_i};

  // the second stage alone feeds the fault logic
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= async_in;
      sync2_r <= sync1_r;
    end
  end

  wire                 en_s     = sync2_r[0];
  wire                 uv_lo_s  = sync2_r[1];
  wire                 uv_hi_s  = sync2_r[2];
  wire                 ovf_s    = sync2_r[3];
  wire                 ovv_s    = sync2_r[4];
  wire                 dlow_s   = sync2_r[5];
  wire                 t28_s    = sync2_r[6];
  wire                 t33lo_s  = sync2_r[7];
  wire                 t33hi_s  = sync2_r[8];
  wire                 t39_s    = sync2_r[9];
  wire                 avg_s    = sync2_r[10];
  wire [`CHANNELS-1:0] chan_s   = sync2_r[NSYNC-1:11];

  // ***************************************************************
  // register port
  // ***************************************************************
  logic        sw_off_r;
  logic [7:0]  retries_r;
  logic [31:0] rdata_r;
  logic [31:0] status_w;

  wire wr_ctrl    = reg_wr_i && (reg_addr_i == `REG_CTRL);
  wire wr_retries = reg_wr_i && (reg_addr_i == `REG_RETRIES);
  wire hit_ctrl   = reg_addr_i == `REG_CTRL;
  wire hit_status = reg_addr_i == `REG_STATUS;
  wire hit_retry  = reg_addr_i == `REG_RETRIES;

  wire [31:0] rd_mux = hit_ctrl   ? {31'h0000_0000, sw_off_r} :
                       hit_status ? status_w :
                       hit_retry  ? {24'h00_0000, retries_r} :
                                    32'h0000_0000;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_off_r <= 1'(`CTRL_RESET);
      rdata_r  <= 32'h0000_0000;
    end else begin
      if (wr_ctrl)
        sw_off_r <= reg_wdata_i[`CTRL_SW_OFF_BIT];
      rdata_r <= reg_rd_i ? rd_mux : 32'h0000_0000;
    end
  end

  assign reg_rdata_o = rdata_r;

  // ***************************************************************
  // main state
  // ***************************************************************
  vr_fault_supervisor_pkg::sup_state_t state_r;
  vr_fault_supervisor_pkg::sup_state_t state_nxt;

  logic        vid_ok_r;
  logic        vid_off_r;
  logic        ov_low_r;
  logic        uv_r;
  logic        restart_r;
  logic [12:0] hic_cnt_r;
  logic [`CHANNELS-1:0] chan_trip;

  wire running = state_r == vr_fault_supervisor_pkg::ST_RUN;
  wire in_hic  = state_r == vr_fault_supervisor_pkg::ST_HICCUP;
  wire in_ov   = state_r == vr_fault_supervisor_pkg::ST_OV;

  // disable sources: enable pins, software off, latched off-code
  wire enable_ok = en_s && !sw_off_r && !vid_off_r;

  // fixed level until a valid VID, then VID-relative level
  wire ov_trip  = vid_ok_r ? ovv_s : ovf_s;
  wire oc_trip  = avg_s || (|chan_trip);
  wire hic_done = sw_cycle_tick_i &&
                  (hic_cnt_r == 13'(HICCUP_CYCLES - 1));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      vr_fault_supervisor_pkg::ST_OFF: begin
        if (enable_ok)
          state_nxt = vr_fault_supervisor_pkg::ST_RUN;
      end
      vr_fault_supervisor_pkg::ST_RUN: begin
        if (!enable_ok)
          state_nxt = vr_fault_supervisor_pkg::ST_OFF;
        else if (oc_trip)
          state_nxt = vr_fault_supervisor_pkg::ST_HICCUP;
      end
      vr_fault_supervisor_pkg::ST_HICCUP: begin
        if (!enable_ok)
          state_nxt = vr_fault_supervisor_pkg::ST_OFF;
        else if (hic_done)
          state_nxt = vr_fault_supervisor_pkg::ST_RUN;
      end
      vr_fault_supervisor_pkg::ST_OV: begin
        // only an enable drop or software off leaves; VID activity is ignored here
        if (!en_s || sw_off_r)
          state_nxt = vr_fault_supervisor_pkg::ST_OFF;
      end
    endcase
    // guard watches in every state, including shutdown
    if (ov_trip)
      state_nxt = vr_fault_supervisor_pkg::ST_OV;
  end

  wire enter_run = (state_nxt == vr_fault_supervisor_pkg::ST_RUN) &&
                   !running;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r   <= vr_fault_supervisor_pkg::ST_OFF;
      restart_r <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      restart_r <= enter_run;
    end
  end

  // ***************************************************************
  // VID tracking and off-code latch
  // ***************************************************************
  wire vid_ok_nxt  = running && (vid_ok_r || vid_valid_i);
  // off-code latch clears only when the enables themselves drop
  wire vid_off_nxt = en_s && (vid_off_r || (running && vid_off_i));

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      vid_ok_r  <= 1'b0;
      vid_off_r <= 1'b0;
    end else begin
      vid_ok_r  <= vid_ok_nxt;
      vid_off_r <= vid_off_nxt;
    end
  end

  // ***************************************************************
  // overvoltage drive-low phase
  // ***************************************************************
  // a new trip wins over the diff-sense release in the same cycle
  wire ov_low_nxt = ov_trip ||
                    (ov_low_r && in_ov && !dlow_s);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      ov_low_r <= 1'b0;
    else
      ov_low_r <= ov_low_nxt;
  end

  // ***************************************************************
  // per-channel overcurrent run counters
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < `CHANNELS; g++) begin : g_chan
      logic [3:0] run_r;
      wire        full = run_r == 4'(`CHAN_OC_RUN);
      assign chan_trip[g] = full;
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
          run_r <= 4'h0;
        else if (!running)
          run_r <= 4'h0;
        else if (sw_cycle_tick_i) begin
          if (!chan_s[g])
            run_r <= 4'h0;
          else if (!full)
            run_r <= run_r + 4'h1;
        end
      end
    end
  endgenerate

  // ***************************************************************
  // hiccup wait and retry counter
  // ***************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      hic_cnt_r <= 13'h0000;
    else if (!in_hic)
      hic_cnt_r <= 13'h0000;
    else if (sw_cycle_tick_i)
      hic_cnt_r <= hic_cnt_r + 13'h0001;
  end

  // hardware increment wins over a software clear
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i)
      retries_r <= 8'h00;
    else if (running && oc_trip && enable_ok && !ov_trip) begin
      if (retries_r != 8'hff)
        retries_r <= retries_r + 8'h01;
    end else if (wr_retries)
      retries_r <= 8'h00;
  end

  // ***************************************************************
  // undervoltage hysteresis and ready delay
  // ***************************************************************
  logic [14:0] rdy_cnt_r;
  logic        rdy_r;
  logic        pgood_r;

  wire uv_nxt   = running && (uv_lo_s || (uv_r && !uv_hi_s));
  wire ss_ok    = running && softstart_done_i;
  wire rdy_hit  = rdy_cnt_r == 15'(READY_DELAY_CYCLES - 1);
  wire pg_nxt   = ss_ok && rdy_r && !uv_nxt &&
                  !ov_trip && enable_ok;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      uv_r      <= 1'b0;
      rdy_cnt_r <= 15'h0000;
      rdy_r     <= 1'b0;
      pgood_r   <= 1'b0;
    end else begin
      uv_r <= uv_nxt;
      if (!ss_ok) begin
        rdy_cnt_r <= 15'h0000;
        rdy_r     <= 1'b0;
      end else if (!rdy_r) begin
        rdy_cnt_r <= rdy_cnt_r + 15'h0001;
        rdy_r     <= rdy_hit;
      end
      pgood_r <= pg_nxt;
    end
  end

  // ***************************************************************
  // thermal hysteresis
  // ***************************************************************
  logic fan_pull_r;
  logic hot_pull_r;

  // rising-side threshold wins if both flags glitch together
  wire fan_nxt = t39_s || (fan_pull_r && !t33lo_s);
  wire hot_nxt = t33hi_s || (hot_pull_r && !t28_s);

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fan_pull_r <= 1'b0;
      hot_pull_r <= 1'b0;
    end else begin
      fan_pull_r <= fan_nxt;
      hot_pull_r <= hot_nxt;
    end
  end

  // ***************************************************************
  // PWM gating
  // ***************************************************************
  logic [`CHANNELS-1:0] pwm_r;
  logic [`CHANNELS-1:0] pwm_oe_r;

  // registered from next-state terms so a trip reaches the pins in one edge
  wire normal_nxt = (state_nxt == vr_fault_supervisor_pkg::ST_RUN);
  wire drive_low  = (state_nxt == vr_fault_supervisor_pkg::ST_OV) &&
                    ov_low_nxt;
  wire [`CHANNELS-1:0] pwm_nxt = normal_nxt ? pwm_i : '0;
  wire [`CHANNELS-1:0] oe_nxt  = (normal_nxt || drive_low) ?
                                 {`CHANNELS{1'b1}} : '0;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pwm_r    <= '0;
      pwm_oe_r <= '0;
    end else begin
      pwm_r    <= pwm_nxt;
      pwm_oe_r <= oe_nxt;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign pwm_o                   = pwm_r;
  assign pwm_oe_o                = pwm_oe_r;
  // open drain: the data level is always low, the enable pulls
  assign power_good_out_o        = 1'b0;
  assign power_good_out_oe_o     = !pgood_r;
  assign fan_request_out_o       = 1'b0;
  assign fan_request_out_oe_o    = fan_pull_r;
  assign overtemp_alert_out_o    = 1'b0;
  assign overtemp_alert_out_oe_o = hot_pull_r;
  assign softstart_run_o         = running;
  assign softstart_restart_o     = restart_r;

  always_comb begin
    status_w = 32'h0000_0000;
    status_w[`ST_PGOOD_BIT]   = pgood_r;
    status_w[`ST_OV_LATCH_BIT] = in_ov;
    status_w[`ST_OV_LOW_BIT]  = ov_low_r;
    status_w[`ST_HICCUP_BIT]  = in_hic;
    status_w[`ST_UV_BIT]      = uv_r;
    status_w[`ST_FAN_BIT]     = fan_pull_r;
    status_w[`ST_HOT_BIT]     = hot_pull_r;
    status_w[`ST_VID_OK_BIT]  = vid_ok_r;
    status_w[`ST_VID_OFF_BIT] = vid_off_r;
    status_w[`ST_STATE_LSB +: 2] = state_r;
  end

endmodule

// File: tb/mosfet_driver_model.sv
// behavioural MOSFET drivers and power good monitor beyond the supervisor
`timescale 1ns/1ps
`include "vr_fault_supervisor_params.svh"
module mosfet_driver_model (
  input  wire logic [`CHANNELS-1:0] pwm_i,
  input  wire logic [`CHANNELS-1:0] pwm_oe_i,
  input  wire logic                 pg_i,
  input  wire logic                 pg_oe_i,
  output logic      [`CHANNELS-1:0] low_fet_on_o,
  output logic      [`CHANNELS-1:0] both_off_o,
  output logic                      pg_line_o
);
  // a floating pwm pin sits mid-rail, read by the drivers as both off
  assign both_off_o   = ~pwm_oe_i;
  assign low_fet_on_o = pwm_oe_i & ~pwm_i;
  // pull-up on the open-drain line wins whenever nobody pulls it
  assign pg_line_o    = pg_oe_i ? pg_i : 1'b1;
endmodule

// File: tb/vr_fault_supervisor_asserts.sv
// concurrent checks on the fault supervisor pins
`timescale 1ns/1ps
`include "vr_fault_supervisor_params.svh"
module vr_fault_supervisor_asserts #(
  parameter int unsigned READY_DELAY_CYCLES = 20,
  parameter int unsigned HICCUP_CYCLES      = 8
) (
  input wire logic                 ref_clk_i,
  input wire logic                 rst_n_i,
  input wire logic                 power_enable_in_i,
  input wire logic                 rail_enable_in_i,
  input wire logic                 uv_below_half_i,
  input wire logic                 ov_fixed_trip_i,
  input wire logic                 diff_sense_low_i,
  input wire logic                 avg_oc_i,
  input wire logic                 tm_above_33_i,
  input wire logic                 tm_above_39_i,
  input wire logic                 sw_cycle_tick_i,
  input wire logic                 softstart_done_i,
  input wire logic [`ADDR_W-1:0]   reg_addr_i,
  input wire logic [31:0]          reg_wdata_i,
  input wire logic                 reg_wr_i,
  input wire logic                 softstart_run_o,
  input wire logic                 softstart_restart_o,
  input wire logic [`CHANNELS-1:0] pwm_o,
  input wire logic [`CHANNELS-1:0] pwm_oe_o,
  input wire logic                 power_good_out_oe_o,
  input wire logic                 fan_request_out_o,
  input wire logic                 fan_request_out_oe_o,
  input wire logic                 overtemp_alert_out_o,
  input wire logic                 overtemp_alert_out_oe_o
);
  logic        off_r, ov_r, hic_r;
  logic [7:0]  tck_r;
  logic [15:0] rdy_r;
  // raw enables lead the design's synchronised copy, so helpers clear early
  wire         en_w      = power_enable_in_i && rail_enable_in_i && !off_r;
  wire         drv_low_w = (&pwm_oe_o) && !(|pwm_o) && !softstart_run_o;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      off_r <= 1'b0;
      ov_r  <= 1'b0;
      hic_r <= 1'b0;
      tck_r <= 8'h00;
      rdy_r <= 16'h0000;
    end else begin
      if (reg_wr_i && reg_addr_i == `REG_CTRL)
        off_r <= reg_wdata_i[`CTRL_SW_OFF_BIT];
      ov_r  <= en_w && (ov_r || drv_low_w);
      hic_r <= en_w && (hic_r || $fell(softstart_run_o));
      tck_r <= $fell(softstart_run_o) ? 8'h00 : tck_r + 8'(sw_cycle_tick_i);
      rdy_r <= (softstart_run_o && softstart_done_i) ? rdy_r + 16'h0001
                                                      : 16'h0000;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_ov_drive_low: assert property ($rose(ov_fixed_trip_i) && !softstart_run_o
    |-> ##[1:5] drv_low_w) else $error("pwm not driven low");
  a_ov_hold_low: assert property ((!diff_sense_low_i && en_w)[*3] ##0 drv_low_w
    |=> drv_low_w || !en_w) else $error("drive low dropped");
  a_ov_release: assert property ($rose(diff_sense_low_i) && drv_low_w &&
    !ov_fixed_trip_i |-> ##[1:5] pwm_oe_o == '0) else $error("no hi-z");
  a_ov_stays_latched: assert property (ov_r |-> !softstart_run_o)
    else $error("switching after overvoltage");
  a_oc_avg_hiz: assert property ($rose(avg_oc_i) && softstart_run_o
    |-> ##[1:5] pwm_oe_o == '0) else $error("no overcurrent hi-z");
  a_hiccup_len: assert property ($rose(softstart_run_o) && hic_r
    |-> tck_r >= HICCUP_CYCLES - 1 && tck_r <= HICCUP_CYCLES + 1)
    else $error("hiccup wait length");
  a_restart_pulse: assert property ($rose(softstart_run_o)
    |-> softstart_restart_o ##1 !softstart_restart_o)
    else $error("restart pulse");
  a_pgood_early: assert property ($fell(power_good_out_oe_o)
    |-> rdy_r >= READY_DELAY_CYCLES) else $error("power good early");
  a_pgood_off: assert property (!softstart_run_o && !$past(softstart_run_o)
    |-> power_good_out_oe_o) else $error("power good off");
  a_uv_pull: assert property ($rose(uv_below_half_i)
    |-> ##[1:5] power_good_out_oe_o) else $error("uv pull");
  a_fan_pull: assert property ($rose(tm_above_39_i)
    |-> ##[1:5] fan_request_out_oe_o) else $error("fan pull");
  a_hot_pull: assert property ($rose(tm_above_33_i)
    |-> ##[1:5] overtemp_alert_out_oe_o) else $error("hot pull");
  a_od_low_only: assert property (!fan_request_out_o && !overtemp_alert_out_o)
    else $error("open drain drives high");
  c_hiccup: cover property ($rose(softstart_run_o) && hic_r);
  c_ov: cover property (drv_low_w);
  c_pgood: cover property ($fell(power_good_out_oe_o));
endmodule

bind vr_fault_supervisor vr_fault_supervisor_asserts #(
  .READY_DELAY_CYCLES(READY_DELAY_CYCLES),
  .HICCUP_CYCLES(HICCUP_CYCLES)
) u_vr_fault_supervisor_asserts (.*);

// File: tb/vr_fault_supervisor_test.sv
// self-checking bench for the fault supervisor
`timescale 1ns/1ps
`include "vr_fault_supervisor_params.svh"
`define CMP(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module vr_fault_supervisor_test;
  typedef struct { string nm; logic [31:0] m; logic [31:0] e; } note_t;
  logic                 ref_clk_i = 1'b0;
  logic                 rst_n_i, power_enable_in_i, rail_enable_in_i, rd_q;
  logic                 uv_below_half_i, uv_above_sixty_i, ov_fixed_trip_i;
  logic                 ov_vid_trip_i, diff_sense_low_i, avg_oc_i, pg_line;
  logic                 tm_below_28_i, tm_below_33_i, tm_above_33_i;
  logic                 tm_above_39_i, sw_cycle_tick_i, softstart_done_i;
  logic                 vid_valid_i, vid_off_i, reg_wr_i, reg_rd_i;
  logic [`CHANNELS-1:0] chan_oc_i, pwm_i, pwm_o, pwm_oe_o, low_on, both_off;
  logic [`ADDR_W-1:0]   reg_addr_i;
  logic [31:0]          reg_wdata_i, reg_rdata_o;
  logic                 softstart_run_o, softstart_restart_o;
  logic                 power_good_out_o, power_good_out_oe_o;
  logic                 fan_request_out_o, fan_request_out_oe_o;
  logic                 overtemp_alert_out_o, overtemp_alert_out_oe_o;
  logic [1:0]           tk;
  int                   n_errors = 0, checks = 0, seed = 48364;
  note_t                q[$];
  int                   tv[6] = '{30, 36, 40, 36, 30, 25};
  logic [31:0]          te[6] = '{32'h0000_0000, 32'h0000_0040, 32'h0000_0060,
                                  32'h0000_0060, 32'h0000_0040, 32'h0000_0000};
  vr_fault_supervisor #(.READY_DELAY_CYCLES(20), .HICCUP_CYCLES(8))
    u_vr_fault_supervisor (.*);
  mosfet_driver_model u_mosfet_driver_model (.pwm_i(pwm_o),
    .pwm_oe_i(pwm_oe_o), .pg_i(power_good_out_o),
    .pg_oe_i(power_good_out_oe_o), .low_fet_on_o(low_on),
    .both_off_o(both_off), .pg_line_o(pg_line));
  always #2 ref_clk_i = ~ref_clk_i;
  // switching-cycle tick every fourth clock keeps hiccup waits short
  always @(posedge ref_clk_i) begin
    tk <= tk + 2'd1;
    sw_cycle_tick_i <= (tk == 2'd3);
    pwm_i <= 6'($random(seed));
  end
  always @(posedge ref_clk_i) begin
    if (rd_q) begin
      `CMP(q[0].nm, q[0].e, reg_rdata_o & q[0].m)
      void'(q.pop_front());
    end
    rd_q <= reg_rd_i;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e, string nm);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    q.push_back('{nm, m, e});
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
  endtask
  task automatic st(input logic [31:0] m, e);
    rd(`REG_STATUS, m, e, "status");
    cyc(1);
  endtask
  task automatic tm(input int v);
    tm_below_28_i <= (v < 28);
    tm_below_33_i <= (v < 33);
    tm_above_33_i <= (v > 33);
    tm_above_39_i <= (v > 39);
  endtask
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_for(input bit pg, input logic lvl);
    int n;
    n = 0;
    while (((pg ? pg_line : softstart_run_o) !== lvl) && n < 500) begin
      @(posedge ref_clk_i);
      n++;
    end
    if (n >= 500) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  task automatic up();
    wait_for(1'b0, 1'b1);
    wait_for(1'b1, 1'b1);
  endtask
  initial begin
    {rst_n_i, power_enable_in_i, rail_enable_in_i, uv_below_half_i, rd_q,
     ov_fixed_trip_i, ov_vid_trip_i, diff_sense_low_i, avg_oc_i, reg_rd_i,
     tm_above_33_i, tm_above_39_i, sw_cycle_tick_i, softstart_done_i,
     vid_valid_i, vid_off_i, reg_wr_i} = '0;
    {chan_oc_i, pwm_i, reg_addr_i, reg_wdata_i, tk} = '0;
    {uv_above_sixty_i, tm_below_28_i, tm_below_33_i} = 3'b111;
    cyc(4);
    rst_n_i <= 1'b1;
    st(32'h0000_30FF, 32'h0000_0000);
    `CMP("both_off", 6'h3F, both_off)
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped");
    rd(`REG_CTRL, 32'hFFFF_FFFF, `CTRL_RESET, "ctrl");
    // overvoltage while disabled, judged by the checker
    ov_fixed_trip_i <= 1'b1;
    cyc(8);
    {ov_fixed_trip_i, diff_sense_low_i} <= 2'b01;
    cyc(8);
    {diff_sense_low_i, power_enable_in_i, rail_enable_in_i} <= 3'b011;
    wait_for(1'b0, 1'b1);
    softstart_done_i <= 1'b1;
    wait_for(1'b1, 1'b1);
    st(32'h0000_3011, 32'h0000_1001);
    {uv_below_half_i, uv_above_sixty_i} <= 2'b10;
    cyc(6);
    st(32'h0000_0011, 32'h0000_0010);
    uv_below_half_i <= 1'b0;
    cyc(6);
    st(32'h0000_0011, 32'h0000_0010);
    uv_above_sixty_i <= 1'b1;
    cyc(6);
    st(32'h0000_0011, 32'h0000_0001);
    vid_valid_i <= 1'b1;
    cyc(1);
    {vid_valid_i, ov_fixed_trip_i} <= 2'b01;
    cyc(6);
    st(32'h0000_3083, 32'h0000_1081);
    {ov_fixed_trip_i, ov_vid_trip_i} <= 2'b01;
    cyc(6);
    st(32'h0000_3007, 32'h0000_3006);
    `CMP("low_on", 6'h3F, low_on)
    {ov_vid_trip_i, vid_valid_i} <= 2'b01;
    cyc(1);
    vid_valid_i <= 1'b0;
    cyc(20);
    st(32'h0000_3006, 32'h0000_3006);
    diff_sense_low_i <= 1'b1;
    cyc(6);
    st(32'h0000_3006, 32'h0000_3002);
    `CMP("both_off", 6'h3F, both_off)
    {diff_sense_low_i, ov_fixed_trip_i} <= 2'b01;
    cyc(6);
    st(32'h0000_3006, 32'h0000_3006);
    {diff_sense_low_i, ov_fixed_trip_i, rail_enable_in_i} <= 3'b100;
    cyc(6);
    st(32'h0000_3000, 32'h0000_0000);
    {diff_sense_low_i, rail_enable_in_i} <= 2'b01;
    up();
    avg_oc_i <= 1'b1;
    cyc(6);
    st(32'h0000_3008, 32'h0000_2008);
    `CMP("both_off", 6'h3F, both_off)
    wait_for(1'b0, 1'b1);
    wait_for(1'b0, 1'b0);
    avg_oc_i <= 1'b0;
    wait_for(1'b0, 1'b1);
    rd(`REG_RETRIES, 32'h0000_00FF, 32'h0000_0002, "retries");
    wr(`REG_RETRIES, 32'h0000_0000);
    rd(`REG_RETRIES, 32'h0000_00FF, 32'h0000_0000, "retries");
    chan_oc_i <= 6'h08;
    cyc(24);
    chan_oc_i <= 6'h00;
    cyc(8);
    st(32'h0000_3000, 32'h0000_1000);
    chan_oc_i <= 6'h08;
    cyc(44);
    st(32'h0000_3000, 32'h0000_2000);
    chan_oc_i <= 6'h00;
    up();
    wr(`REG_CTRL, 32'h0000_0001);
    cyc(4);
    st(32'h0000_3001, 32'h0000_0000);
    rd(`REG_CTRL, 32'hFFFF_FFFF, 32'h0000_0001, "ctrl");
    wr(`REG_CTRL, 32'h0000_0000);
    up();
    vid_off_i <= 1'b1;
    cyc(1);
    vid_off_i <= 1'b0;
    cyc(26);
    st(32'h0000_3001, 32'h0000_0000);
    power_enable_in_i <= 1'b0;
    cyc(4);
    power_enable_in_i <= 1'b1;
    up();
    for (int i = 0; i < 6; i++) begin
      tm(tv[i]);
      cyc(6);
      st(32'h0000_0060, te[i]);
    end
    cyc(4);
    tally_and_finish();
  end
endmodule
